// >>> verilog/tws_pkg.sv
// package: register map, field layout, reset values and types of the wave-shaping timer
package tws_pkg;

  localparam int          ADR_W          = 8;
  localparam int          DAT_W          = 32;
  localparam int          CNT_W          = 4;
  localparam int          TRIM_W         = 3;

  // register indices; byte address is four times the index
  localparam logic [5:0]  IDX_CLAMP_REL  = 6'h34;
  localparam logic [5:0]  IDX_SUPPLY_RES = 6'h35;
  localparam logic [5:0]  IDX_STOP_RET   = 6'h36;
  localparam logic [5:0]  IDX_CLAMP_REC  = 6'h37;
  localparam logic [5:0]  IDX_RES_REST   = 6'h38;
  localparam logic [5:0]  IDX_TRIM_RO    = 6'h39;
  localparam logic [5:0]  IDX_STATUS     = 6'h3a;

  // nibble positions inside an 8-bit register
  localparam int          NIB_LO         = 0;
  localparam int          NIB_HI         = 4;

  // status register bit positions
  localparam int          ST_DRV_LSB     = 0;
  localparam int          ST_MOD_BIT     = 4;
  localparam int          ST_RUN_BIT     = 5;
  localparam int          ST_TRAIL_BIT   = 6;
  localparam int          ST_ORDER_BIT   = 7;

  // values after reset, the last count of the delay counter and the zero read word
  localparam logic [3:0]  RST_DELAY      = 4'h0;
  localparam logic [2:0]  RST_TRIM       = 3'h0;
  localparam logic [3:0]  CNT_LAST       = 4'hf;
  localparam logic [31:0] RD_ZERO        = 32'h0000_0000;

  typedef struct packed {
    logic [3:0] clamp_release_delay;
    logic [3:0] mod_supply_start_delay;
    logic [3:0] mod_resistance_delay;
    logic [3:0] drive_stop_delay;
    logic [3:0] rf_supply_return_delay;
    logic [3:0] clamp_reconnect_delay;
    logic [3:0] drive_resistance_restore_delay;
  } tws_timing_t;

  typedef struct packed {
    logic clamp_released;
    logic on_modulation_supply;
    logic modulation_resistance;
    logic drive_stopped;
  } tws_drv_t;

  typedef enum {
    TWS_IDLE,
    TWS_LEAD,
    TWS_HOLD,
    TWS_TRAIL
  } tws_phase_t;

endpackage : tws_pkg

// >>> verilog/tws_delay_counter.sv
// module: carrier-period counter restarted at each modulation edge
module tws_delay_counter (
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  input  wire logic                       start,
  output logic [tws_pkg::CNT_W-1:0]       count,
  output logic                            running
);

  // count runs 0..15 after a start, then parks; a fresh start restarts it
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      count   <= tws_pkg::RST_DELAY;
      running <= 1'b0;
    end
    else if (start)
    begin
      count   <= tws_pkg::RST_DELAY;
      running <= 1'b1;
    end
    else if (running)
    begin
      if (count == tws_pkg::CNT_LAST)
      begin
        running <= 1'b0;
      end
      else
      begin
        count <= count + 4'h1;
      end
    end
  end

endmodule : tws_delay_counter

// >>> verilog/tws_wave_timer.sv
// module: wave-shaping timer for the transmit driver with a classic wishbone slave
// Function
// - release the supply clamp after the clamp release delay in carrier periods
// - after modulation supply start delay, move driver onto the modulation supply
// - switch driver to modulation resistance after the first resistance delay
// - stop the transmit driver after the drive stop delay
// - return the driver onto the rf supply after the return delay
// - reconnect the supply clamp after the clamp reconnect delay
// - restore driving resistance after the second resistance delay
// - report a read-only 3-bit oscillator trim result, centre code 011b
//
// Added by the designer: the Wishbone interface to the registers.
module tws_wave_timer (
  input  wire logic                         mclk,
  input  wire logic                         rst_b,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [tws_pkg::ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [tws_pkg::DAT_W-1:0]    wb_dat_i,
  output logic      [tws_pkg::DAT_W-1:0]    wb_dat_o,
  output logic                              wb_ack_o,
  input  wire logic                         mod_start,
  input  wire logic                         mod_end,
  input  wire logic [tws_pkg::TRIM_W-1:0]   oscillator_trim_in,
  output tws_pkg::tws_drv_t                 drv
);

  tws_pkg::tws_timing_t                     tim;
  tws_pkg::tws_phase_t                      phase;
  tws_pkg::tws_phase_t                      next_phase;
  logic [tws_pkg::TRIM_W-1:0]               trim_meta;
  logic [tws_pkg::TRIM_W-1:0]               oscillator_trim_readout;
  logic [tws_pkg::CNT_W-1:0]                count;
  logic                                     running;
  logic                                     cnt_start;
  logic                                     bus_req;
  logic                                     bus_wr;
  logic [5:0]                               idx;
  logic                                     aligned;
  logic [7:0]                               wr_byte;
  logic [tws_pkg::DAT_W-1:0]                next_dat;
  logic                                     lead_on;
  logic                                     trail_on;
  logic                                     fire_clamp_rel;
  logic                                     fire_supply;
  logic                                     fire_mod_res;
  logic                                     fire_stop;
  logic                                     fire_return;
  logic                                     fire_clamp_rec;
  logic                                     fire_res_rest;
  logic                                     order_warn;

  // bus decode
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign idx     = wb_adr_i[7:2];
  assign aligned = (wb_adr_i[1:0] == 2'h0);
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0] & aligned;
  assign wr_byte = wb_dat_i[7:0];

  // ack one cycle after the request, dropped the cycle after; unmapped reads give zero
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= bus_req;
    end
  end

  // timing fields; reserved nibbles are not stored, so they always read zero
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      tim.clamp_release_delay            <= tws_pkg::RST_DELAY;
      tim.mod_supply_start_delay         <= tws_pkg::RST_DELAY;
      tim.mod_resistance_delay           <= tws_pkg::RST_DELAY;
      tim.drive_stop_delay               <= tws_pkg::RST_DELAY;
      tim.rf_supply_return_delay         <= tws_pkg::RST_DELAY;
      tim.clamp_reconnect_delay          <= tws_pkg::RST_DELAY;
      tim.drive_resistance_restore_delay <= tws_pkg::RST_DELAY;
    end
    else if (bus_wr)
    begin
      unique case (idx)
        tws_pkg::IDX_CLAMP_REL:
        begin
          tim.clamp_release_delay <= wr_byte[tws_pkg::NIB_LO +: 4];
        end
        tws_pkg::IDX_SUPPLY_RES:
        begin
          tim.mod_supply_start_delay <= wr_byte[tws_pkg::NIB_HI +: 4];
          tim.mod_resistance_delay   <= wr_byte[tws_pkg::NIB_LO +: 4];
        end
        tws_pkg::IDX_STOP_RET:
        begin
          tim.drive_stop_delay       <= wr_byte[tws_pkg::NIB_HI +: 4];
          tim.rf_supply_return_delay <= wr_byte[tws_pkg::NIB_LO +: 4];
        end
        tws_pkg::IDX_CLAMP_REC:
        begin
          tim.clamp_reconnect_delay <= wr_byte[tws_pkg::NIB_LO +: 4];
        end
        tws_pkg::IDX_RES_REST:
        begin
          tim.drive_resistance_restore_delay <= wr_byte[tws_pkg::NIB_HI +: 4];
        end
        default:
        begin
          tim <= tim;
        end
      endcase
    end
  end

  // read mux
  always_comb
  begin
    next_dat = tws_pkg::RD_ZERO;
    if (aligned)
    begin
      unique case (idx)
        tws_pkg::IDX_CLAMP_REL:
        begin
          next_dat[tws_pkg::NIB_LO +: 4] = tim.clamp_release_delay;
        end
        tws_pkg::IDX_SUPPLY_RES:
        begin
          next_dat[tws_pkg::NIB_HI +: 4] = tim.mod_supply_start_delay;
          next_dat[tws_pkg::NIB_LO +: 4] = tim.mod_resistance_delay;
        end
        tws_pkg::IDX_STOP_RET:
        begin
          next_dat[tws_pkg::NIB_HI +: 4] = tim.drive_stop_delay;
          next_dat[tws_pkg::NIB_LO +: 4] = tim.rf_supply_return_delay;
        end
        tws_pkg::IDX_CLAMP_REC:
        begin
          next_dat[tws_pkg::NIB_LO +: 4] = tim.clamp_reconnect_delay;
        end
        tws_pkg::IDX_RES_REST:
        begin
          next_dat[tws_pkg::NIB_HI +: 4] = tim.drive_resistance_restore_delay;
        end
        tws_pkg::IDX_TRIM_RO:
        begin
          next_dat[tws_pkg::TRIM_W-1:0] = oscillator_trim_readout;
        end
        tws_pkg::IDX_STATUS:
        begin
          next_dat[tws_pkg::ST_DRV_LSB +: 4] = drv;
          next_dat[tws_pkg::ST_MOD_BIT]      = (phase == tws_pkg::TWS_LEAD) |
                                               (phase == tws_pkg::TWS_HOLD);
          next_dat[tws_pkg::ST_RUN_BIT]      = running;
          next_dat[tws_pkg::ST_TRAIL_BIT]    = (phase == tws_pkg::TWS_TRAIL);
          next_dat[tws_pkg::ST_ORDER_BIT]    = order_warn;
        end
        default:
        begin
          next_dat = tws_pkg::RD_ZERO;
        end
      endcase
    end
  end

  // read data is captured with the ack and held until the next request
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      wb_dat_o <= tws_pkg::RD_ZERO;
    end
    else if (bus_req)
    begin
      wb_dat_o <= next_dat;
    end
  end

  // trim code arrives from the analogue side, so it is synchronised first
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      trim_meta               <= tws_pkg::RST_TRIM;
      oscillator_trim_readout <= tws_pkg::RST_TRIM;
    end
    else
    begin
      trim_meta               <= oscillator_trim_in;
      oscillator_trim_readout <= trim_meta;
    end
  end

  // a start later than the clamp release would switch supplies against the clamp
  assign order_warn = (tim.mod_supply_start_delay > tim.clamp_release_delay);

  // phase sequencing; an end during the leading window jumps straight to trailing
  always_comb
  begin
    next_phase = phase;
    unique case (phase)
      tws_pkg::TWS_IDLE:
      begin
        if (mod_start)
        begin
          next_phase = tws_pkg::TWS_LEAD;
        end
      end
      tws_pkg::TWS_LEAD:
      begin
        if (mod_end)
        begin
          next_phase = tws_pkg::TWS_TRAIL;
        end
        else if (!running)
        begin
          next_phase = tws_pkg::TWS_HOLD;
        end
      end
      tws_pkg::TWS_HOLD:
      begin
        if (mod_end)
        begin
          next_phase = tws_pkg::TWS_TRAIL;
        end
      end
      tws_pkg::TWS_TRAIL:
      begin
        if (mod_start)
        begin
          next_phase = tws_pkg::TWS_LEAD;
        end
        else if (!running)
        begin
          next_phase = tws_pkg::TWS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      phase <= tws_pkg::TWS_IDLE;
    end
    else
    begin
      phase <= next_phase;
    end
  end

  // counter restarts on every edge that opens a window
  assign cnt_start = (next_phase == tws_pkg::TWS_LEAD  && phase != tws_pkg::TWS_LEAD) |
                     (next_phase == tws_pkg::TWS_TRAIL && phase != tws_pkg::TWS_TRAIL);

  tws_delay_counter u_counter (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .start   (cnt_start),
    .count   (count),
    .running (running)
  );

  // window gating keeps a stale count from firing actions of the other edge
  assign lead_on  = running & (phase == tws_pkg::TWS_LEAD);
  assign trail_on = running & (phase == tws_pkg::TWS_TRAIL);

  assign fire_clamp_rel = lead_on  & (count == tim.clamp_release_delay);
  assign fire_supply    = lead_on  & (count == tim.mod_supply_start_delay);
  assign fire_mod_res   = lead_on  & (count == tim.mod_resistance_delay);
  assign fire_stop      = trail_on & (count == tim.drive_stop_delay);
  assign fire_return    = trail_on & (count == tim.rf_supply_return_delay);
  assign fire_clamp_rec = trail_on & (count == tim.clamp_reconnect_delay);
  assign fire_res_rest  = trail_on & (count == tim.drive_resistance_restore_delay);

  // supply clamp
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      drv.clamp_released <= 1'b0;
    end
    else if (fire_clamp_rel)
    begin
      drv.clamp_released <= 1'b1;
    end
    else if (fire_clamp_rec)
    begin
      drv.clamp_released <= 1'b0;
    end
  end

  // driver supply selection
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      drv.on_modulation_supply <= 1'b0;
    end
    else if (fire_supply)
    begin
      drv.on_modulation_supply <= 1'b1;
    end
    else if (fire_return)
    begin
      drv.on_modulation_supply <= 1'b0;
    end
  end

  // driver resistance
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      drv.modulation_resistance <= 1'b0;
    end
    else if (fire_mod_res)
    begin
      drv.modulation_resistance <= 1'b1;
    end
    else if (fire_res_rest)
    begin
      drv.modulation_resistance <= 1'b0;
    end
  end

  // driver stop lasts until the trailing window closes or a new interval opens
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      drv.drive_stopped <= 1'b0;
    end
    else if (fire_stop)
    begin
      drv.drive_stopped <= 1'b1;
    end
    else if (cnt_start || (phase == tws_pkg::TWS_TRAIL && !running))
    begin
      drv.drive_stopped <= 1'b0;
    end
  end

endmodule : tws_wave_timer

// >>> dv/tws_driver_model.sv
// model: transmit driver stage, source of the oscillator trim code
module tws_driver_model (
  input  wire logic       mclk,
  input  wire logic [2:0] trim_set,
  output logic      [2:0] trim_code
);
  timeunit 1ns;
  timeprecision 1ns;
  // analogue code settles one carrier period after a change
  always_ff @(posedge mclk)
  begin
    trim_code <= trim_set;
  end
endmodule : tws_driver_model

// >>> dv/tws_wave_timer_sva.sv
// checker: bus answer and drive timing relations of the wave timer
module tws_wave_timer_sva (
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              mod_start,
  input wire logic              mod_end,
  input wire tws_pkg::tws_drv_t drv
);
  logic [7:0] sh [5];
  logic       in_mod;
  logic [4:0] cnt;
  logic       req;
  logic       hit;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign hit = wb_adr_i[1:0] == 2'b00 && wb_adr_i >= 8'hd0 && wb_adr_i <= 8'he0;
  // shadow copy of the timing bytes, taken from the bus itself
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      sh <= '{default: 8'h00};
    else if (req && wb_we_i && wb_sel_i[0] && hit)
      sh[3'((wb_adr_i - 8'hd0) >> 2)] <= wb_dat_i[7:0];
  end
  // carrier periods since the accepted edge; saturates so it never wraps
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      in_mod <= 1'b0;
      cnt    <= 5'h1f;
    end
    else if (mod_start && !in_mod || mod_end && in_mod)
    begin
      in_mod <= !in_mod;
      cnt    <= 5'h00;
    end
    else if (cnt != 5'h1f)
      cnt <= cnt + 5'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  ack_pulse_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer is not a single cycle after the request");
  trim_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'he4 |->
    wb_dat_o[31:3] == 29'h0000_0000) else $error("trim readout has stray bits");
  // a change seen at this edge was decided on the count and window one edge earlier
  clamp_rel_a: assert property ($rose(drv.clamp_released) |->
    $past(in_mod) && $past(cnt) == 5'(sh[0][3:0]))
    else $error("clamp released at wrong count");
  supply_on_a: assert property ($rose(drv.on_modulation_supply) |->
    $past(in_mod) && $past(cnt) == 5'(sh[1][7:4]))
    else $error("supply switch at wrong count");
  mod_res_a: assert property ($rose(drv.modulation_resistance) |->
    $past(in_mod) && $past(cnt) == 5'(sh[1][3:0]))
    else $error("resistance change at wrong count");
  drv_stop_a: assert property ($rose(drv.drive_stopped) |->
    !$past(in_mod) && $past(cnt) == 5'(sh[2][7:4]))
    else $error("drive stop at wrong count");
  rf_return_a: assert property ($fell(drv.on_modulation_supply) |->
    !$past(in_mod) && $past(cnt) == 5'(sh[2][3:0]))
    else $error("supply return at wrong count");
  clamp_rec_a: assert property ($fell(drv.clamp_released) |->
    !$past(in_mod) && $past(cnt) == 5'(sh[3][3:0]))
    else $error("clamp reconnect at wrong count");
  res_restore_a: assert property ($fell(drv.modulation_resistance) |->
    !$past(in_mod) && $past(cnt) == 5'(sh[4][7:4]))
    else $error("resistance restore at wrong count");
  stop_end_a: assert property ($fell(drv.drive_stopped) |->
    in_mod || $past(cnt) == 5'h10) else $error("drive stop cleared before window end");
  cover property ($rose(drv.clamp_released));
  cover property ($fell(drv.drive_stopped));
  cover property (wb_ack_o && !wb_we_i);
endmodule : tws_wave_timer_sva

bind tws_wave_timer tws_wave_timer_sva u_tws_wave_timer_sva (.mclk(mclk), .rst_b(rst_b),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .mod_start(mod_start), .mod_end(mod_end), .drv(drv));

// >>> dv/tws_wave_timer_tb_top.sv
// testbench: register access and wave-shaping timing of the wave timer
module tws_wave_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic               mclk = 1'b0;
  logic               rst_b = 1'b0;
  logic               wb_cyc_i = 1'b0;
  logic               wb_stb_i = 1'b0;
  logic               wb_we_i = 1'b0;
  logic [7:0]         wb_adr_i = 8'h00;
  logic [3:0]         wb_sel_i = 4'h0;
  logic [31:0]        wb_dat_i = 32'h0000_0000;
  logic [31:0]        wb_dat_o;
  logic               wb_ack_o;
  logic               mod_start = 1'b0;
  logic               mod_end = 1'b0;
  logic [2:0]         trim_set = 3'h0;
  logic [2:0]         trim_code;
  tws_pkg::tws_drv_t  drv;
  tws_pkg::tws_timing_t tm;
  logic [3:0]         prev_drv = 4'h0;
  logic [3:0]         exp_drv = 4'h0;
  logic [31:0]        rd_q[$];
  logic [35:0]        ev_q[$];
  int                 cyc_n = 0;
  int                 mismatches = 0;
  int                 check_count = 0;

  tws_driver_model u_tws_driver_model (.mclk(mclk), .trim_set(trim_set), .trim_code(trim_code));
  tws_wave_timer u_tws_wave_timer (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mod_start(mod_start),
    .mod_end(mod_end), .oscillator_trim_in(trim_code), .drv(drv));

  always #25 mclk = ~mclk;
  always @(posedge mclk) cyc_n <= cyc_n + 1;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_rd

  task automatic cmp_drv(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_drv

  // monitor: read data on each read answer, drive state on each change
  always @(posedge mclk)
  begin
    if (rst_b && wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      cmp_rd(wb_dat_o, rd_q.size() > 0 ? rd_q.pop_front() : 32'hffff_ffff);
    if (rst_b && 4'(drv) !== prev_drv)
    begin
      prev_drv = drv;
      cmp_drv({cyc_n, 4'(drv)}, ev_q.size() > 0 ? ev_q.pop_front() : 36'h0);
    end
  end

  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                    input logic [3:0] sel);
    int n;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {8'h00, 16'($urandom), dat};
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1)
    begin
      mismatches++;
      stop_test();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
    rd_q.push_back({24'h00_0000, exp});
    wb(1'b0, adr, 8'h00, 4'hf);
  endtask : rd

  // one modulation edge; expected drive changes land N+2 edges after the pulse
  task automatic window(input logic lead);
    int t0;
    logic [3:0] s;
    @(posedge mclk);
    if (lead)
      mod_start <= 1'b1;
    else
      mod_end <= 1'b1;
    t0 = cyc_n + 1;
    for (int k = 0; k <= 16; k++)
    begin
      if (lead)
        s = {k >= tm.clamp_release_delay, k >= tm.mod_supply_start_delay,
             k >= tm.mod_resistance_delay, 1'b0};
      else
        s = {k < tm.clamp_reconnect_delay, k < tm.rf_supply_return_delay,
             k < tm.drive_resistance_restore_delay, k >= tm.drive_stop_delay && k < 16};
      if (s !== exp_drv)
        ev_q.push_back({t0 + k + 2, s});
      exp_drv = s;
    end
    @(posedge mclk);
    mod_start <= 1'b0;
    mod_end   <= 1'b0;
    repeat (20) @(posedge mclk);
  endtask : window

  initial
  begin
    repeat (30000) @(posedge mclk);
    mismatches++;
    stop_test();
  end

  initial
  begin
    void'($urandom(81349));
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 0; i < 7; i++)
      rd(8'hd0 + 8'(4 * i), 8'h00);
    rd(8'hfc, 8'h00);
    rd(8'hd1, 8'h00);
    $display("test reset values done");
    wb(1'b1, 8'hd0, 8'h05, 4'he);
    wb(1'b1, 8'he4, 8'h07, 4'hf);
    rd(8'hd0, 8'h00);
    @(posedge mclk);
    trim_set <= 3'($urandom);
    repeat (5) @(posedge mclk);
    rd(8'he4, {5'h00, trim_set});
    $display("test refused writes and trim done");
    for (int it = 0; it < 5; it++)
    begin
      tm = it == 0 ? '0 : it == 1 ? '1 : 28'($urandom);
      if (tm.mod_supply_start_delay > tm.clamp_release_delay)
        tm.mod_supply_start_delay = tm.clamp_release_delay;
      wb(1'b1, 8'hd0, {4'h0, tm.clamp_release_delay}, 4'h1);
      wb(1'b1, 8'hd4, {tm.mod_supply_start_delay, tm.mod_resistance_delay}, 4'h1);
      wb(1'b1, 8'hd8, {tm.drive_stop_delay, tm.rf_supply_return_delay}, 4'h1);
      wb(1'b1, 8'hdc, {4'h0, tm.clamp_reconnect_delay}, 4'h1);
      wb(1'b1, 8'he0, {tm.drive_resistance_restore_delay, 4'h0}, 4'h1);
      rd(8'hd4, {tm.mod_supply_start_delay, tm.mod_resistance_delay});
      rd(8'hd8, {tm.drive_stop_delay, tm.rf_supply_return_delay});
      window(1'b1);
      window(1'b0);
      $display("test timing window %0d done", it);
    end
    // early end: a leading action not yet due never fires, trailing ones still do
    wb(1'b1, 8'hd0, 8'h0f, 4'h1);
    for (int a = 8'hd4; a <= 8'he0; a += 4)
      wb(1'b1, 8'(a), 8'h00, 4'h1);
    @(posedge mclk);
    mod_start <= 1'b1;
    ev_q.push_back({cyc_n + 3, 4'h6});
    ev_q.push_back({cyc_n + 4, 4'h1});
    ev_q.push_back({cyc_n + 20, 4'h0});
    @(posedge mclk);
    mod_start <= 1'b0;
    mod_end   <= 1'b1;
    @(posedge mclk);
    mod_end   <= 1'b0;
    rd(8'he8, 8'h61);
    repeat (20) @(posedge mclk);
    // start later than release raises the misorder warning in status
    wb(1'b1, 8'hd0, 8'h00, 4'h1);
    wb(1'b1, 8'hd4, 8'h10, 4'h1);
    rd(8'he8, 8'h80);
    $display("test early end and status done");
    repeat (5) @(posedge mclk);
    if (rd_q.size() != 0 || ev_q.size() != 0)
      mismatches++;
    stop_test();
  end
endmodule : tws_wave_timer_tb_top
